// ---- design/port_police_egress_pkg.sv ----
// Constants, field layouts and types for the port policing and egress queue register bank.
// Functional notes
// - Enable bit turns policing and early drop on.
// - Mode bit picks color-blind or color-aware policing.
// - Stream packets dropped only with permission bit.
// - Remap bit remaps DSCP color when color-aware.
// - Mark bit writes policing color into DSCP.
// - Two-bit non-IP frame color, reset 01.
// - Port-based bit: per port rates, else index zero.
// - Selector picks dropped, green, yellow or red count.
// - Drop-all drops everything above maximum threshold.
// - Color counters count only dropped packets when set.
// - Two-bit queue index selects indexed queue registers.
// - Queue index also reachable as top byte.
// - VID replacement, outer tag when double tagged.
// - Mode 00 is strict priority, queue 3 first.
// - Mode 10, reset value, is weighted round robin.
// - Scheduler codes 01 and 11 are reserved.
// - Shaper 00 none, 01 credit based, reset 00.
// - Port pointer selects port and queue for counters.
package port_police_egress_pkg;

  // Register offsets within one port's 4 KiB window.
  localparam logic [11:0] OFF_PORT_POINTER = 12'h804;
  localparam logic [11:0] OFF_POLICE_CTRL = 12'h80C;
  localparam logic [11:0] OFF_POLICE_COUNT = 12'h820;
  localparam logic [11:0] OFF_TXQ_INDEX = 12'h900;
  localparam logic [11:0] OFF_VID_REPLACE = 12'h904;
  localparam logic [11:0] OFF_TXQ_SCHED = 12'h914;

  // Byte lane that carries the queue index on a byte access.
  localparam logic [1:0] QIDX_BYTE_LANE = 2'h3;

  // AHB-Lite encodings used by the slave.
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Egress scheduler modes; the other two codes are reserved.
  typedef enum logic [1:0] {
    SCHED_STRICT = 2'h0,
    SCHED_WRR = 2'h2
  } sched_mode_t;

  // Egress shaper modes; codes above one are reserved.
  typedef enum logic [1:0] {
    SHAPE_NONE = 2'h0,
    SHAPE_CBS = 2'h1
  } shaper_mode_t;

  // Policing counter selector values.
  typedef enum logic [1:0] {
    CNT_DROPPED = 2'h0,
    CNT_GREEN = 2'h1,
    CNT_YELLOW = 2'h2,
    CNT_RED = 2'h3
  } count_sel_t;

  // Policing control word, bit 11 down to bit 0.
  typedef struct packed {
    logic drop_color_only;
    logic drop_all;
    count_sel_t pkt_type;
    logic port_based;
    logic [1:0] non_ip_frame_color;
    logic mark;
    logic remap;
    logic srp_drop;
    logic color_blind;
    logic enable;
  } police_ctrl_t;

  // Settings as the policing datapath should apply them.
  typedef struct packed {
    logic policing_on;
    logic wred_on;
    logic color_blind;
    logic color_aware;
    logic remap_on;
    logic mark_on;
    logic srp_drop_allowed;
    logic drop_all;
    logic drop_color_only;
    logic [2:0] rate_port_sel;
  } police_eff_t;

  // Port pointer fields; port index sits at bit 16 of the word.
  typedef struct packed {
    logic [2:0] port_index;
    logic [1:0] queue_ptr;
  } port_ptr_t;
  localparam int PTR_PORT_LSB = 16;

  // Per-queue scheduler byte, bits 7:4 of the register.
  typedef struct packed {
    sched_mode_t mode;
    shaper_mode_t shaper;
  } tx_sched_t;

  // Values after reset.
  localparam police_ctrl_t POLICE_CTRL_RST = police_ctrl_t'(12'h020);
  localparam police_eff_t POLICE_EFF_RST = police_eff_t'(12'h000);
  localparam port_ptr_t PORT_PTR_RST = port_ptr_t'(5'h00);
  localparam tx_sched_t TX_SCHED_RST = tx_sched_t'(4'h8);

endpackage

// ---- design/port_police_egress_queue_ctrl.sv ----
// Register bank for per-port policing and egress queue control behind an AHB-Lite slave.
`timescale 1ns/1ps
module port_police_egress_queue_ctrl
  import port_police_egress_pkg::*;
#(
  parameter int NUM_PORTS = 3,
  parameter int NUM_QUEUES = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [15:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [NUM_PORTS-1:0][31:0] policing_packet_counter_count_i,
  input wire logic [NUM_PORTS-1:0] double_tag_en_i,
  output police_ctrl_t [NUM_PORTS-1:0] police_cfg_o,
  output police_eff_t [NUM_PORTS-1:0] police_eff_o,
  output port_ptr_t [NUM_PORTS-1:0] pointer_o,
  output logic [NUM_PORTS-1:0][1:0] tx_queue_index_o,
  output logic [NUM_PORTS-1:0] vid_replace_o,
  output logic [NUM_PORTS-1:0] vid_replace_outer_o,
  output tx_sched_t [NUM_PORTS-1:0][NUM_QUEUES-1:0] tx_sched_o
);

  // Port windows are numbered from one in haddr[15:12]; the pointer holds three bits.
  if (NUM_PORTS < 1 || NUM_PORTS > 7) begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and 7");
  end
  // The queue index is two bits wide.
  if (NUM_QUEUES < 1 || NUM_QUEUES > 4) begin : g_bad_queues
    $error("NUM_QUEUES must lie between 1 and 4");
  end

  localparam int NP = NUM_PORTS;
  localparam int NQ = NUM_QUEUES;

  // Whole state of the block: bus pipeline, answer and every setting.
  typedef struct packed {
    logic wr_pend;
    logic [15:0] wr_addr;
    logic [2:0] wr_size;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    police_ctrl_t [NP-1:0] pol;
    police_eff_t [NP-1:0] eff;
    port_ptr_t [NP-1:0] ptr;
    logic [NP-1:0][1:0] qidx;
    logic [NP-1:0] vid;
    logic [NP-1:0] vid_outer;
    tx_sched_t [NP-1:0][NQ-1:0] sched;
  } state_t;

  // Reset image; the slave is ready and answers OKAY from reset on.
  localparam state_t ST_RST = state_t'({1'b0, 16'h0000, 3'h0, 32'h0000_0000, 1'b1, 1'b0,
    {NP{POLICE_CTRL_RST}}, {NP{POLICE_EFF_RST}}, {NP{PORT_PTR_RST}}, {(2*NP){1'b0}},
    {NP{1'b0}}, {NP{1'b0}}, {(NP*NQ){TX_SCHED_RST}}});

  state_t s_q; // Registered state.
  state_t s_d; // Next state.

  // Word-aligned offset inside a port window.
  function automatic logic [11:0] word_off(input logic [15:0] a);
    word_off = {a[11:2], 2'h0};
  endfunction

  // True when the address falls in the window of port i.
  function automatic logic port_hit(input logic [15:0] a, input int i);
    port_hit = (a[15:12] == 4'(i + 1));
  endfunction

  // Next state: the pending write lands first, so a read right behind it sees it.
  always_comb begin
    s_d = s_q;
    // Data phase of a write taken in the previous cycle.
    if (s_q.wr_pend) begin
      for (int i = 0; i < NP; i++) begin
        if (port_hit(s_q.wr_addr, i)) begin
          unique case (word_off(s_q.wr_addr))
            // Pointer for counters and policing locations.
            OFF_PORT_POINTER: begin
              if (s_q.wr_size == HSIZE_WORD && s_q.wr_addr[1:0] == 2'h0) begin
                s_d.ptr[i].port_index = hwdata_i[PTR_PORT_LSB+:3];
                s_d.ptr[i].queue_ptr = hwdata_i[1:0];
              end
            end
            // Policing control; bits above 11 are dropped.
            OFF_POLICE_CTRL: begin
              if (s_q.wr_size == HSIZE_WORD && s_q.wr_addr[1:0] == 2'h0) begin
                s_d.pol[i] = police_ctrl_t'(hwdata_i[11:0]);
              end
            end
            // Queue index as a word, or as the single byte at the top address.
            OFF_TXQ_INDEX: begin
              if (s_q.wr_size == HSIZE_BYTE && s_q.wr_addr[1:0] == QIDX_BYTE_LANE) begin
                s_d.qidx[i] = hwdata_i[25:24];
              end else if (s_q.wr_size == HSIZE_WORD && s_q.wr_addr[1:0] == 2'h0) begin
                s_d.qidx[i] = hwdata_i[1:0];
              end
            end
            // VID replacement enable.
            OFF_VID_REPLACE: begin
              if (s_q.wr_size == HSIZE_WORD && s_q.wr_addr[1:0] == 2'h0) begin
                s_d.vid[i] = hwdata_i[0];
              end
            end
            // Scheduler byte of the queue that the index names.
            OFF_TXQ_SCHED: begin
              if (s_q.wr_addr[1:0] == 2'h0) begin
                for (int q = 0; q < NQ; q++) begin
                  if (s_q.qidx[i] == 2'(q)) begin
                    // Reserved scheduler codes leave the mode unchanged.
                    if (hwdata_i[7:6] == SCHED_STRICT || hwdata_i[7:6] == SCHED_WRR) begin
                      s_d.sched[i][q].mode = sched_mode_t'(hwdata_i[7:6]);
                    end
                    // Reserved shaper codes leave the shaper unchanged.
                    if (!hwdata_i[5]) begin
                      s_d.sched[i][q].shaper = shaper_mode_t'(hwdata_i[5:4]);
                    end
                  end
                end
              end
            end
            // Unmapped offsets take no effect.
            default: begin
            end
          endcase
        end
      end
    end
    // Settings as applied, derived from the updated control words.
    for (int i = 0; i < NP; i++) begin
      s_d.eff[i].policing_on = s_d.pol[i].enable;
      s_d.eff[i].wred_on = s_d.pol[i].enable;
      s_d.eff[i].color_blind = s_d.pol[i].enable && s_d.pol[i].color_blind;
      s_d.eff[i].color_aware = s_d.pol[i].enable && !s_d.pol[i].color_blind;
      // Remap only matters for color-aware policing.
      s_d.eff[i].remap_on = s_d.eff[i].color_aware && s_d.pol[i].remap;
      s_d.eff[i].mark_on = s_d.pol[i].enable && s_d.pol[i].mark;
      s_d.eff[i].srp_drop_allowed = s_d.pol[i].enable && s_d.pol[i].srp_drop;
      s_d.eff[i].drop_all = s_d.pol[i].enable && s_d.pol[i].drop_all;
      s_d.eff[i].drop_color_only = s_d.pol[i].drop_color_only;
      // Without per-port policing the aggregate rates live at port index zero.
      s_d.eff[i].rate_port_sel = s_d.pol[i].port_based ? s_d.ptr[i].port_index : 3'h0;
      s_d.vid_outer[i] = s_d.vid[i] && double_tag_en_i[i];
    end
    // Address phase of a new transfer.
    s_d.wr_pend = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      if (hwrite_i) begin
        s_d.wr_pend = 1'b1;
        s_d.wr_addr = haddr_i;
        s_d.wr_size = hsize_i;
      end else begin
        // Reads return zero for reserved bits and unmapped offsets.
        s_d.rdata = 32'h0000_0000;
        for (int i = 0; i < NP; i++) begin
          if (port_hit(haddr_i, i)) begin
            unique case (word_off(haddr_i))
              OFF_PORT_POINTER: begin
                s_d.rdata = {13'h0000, s_d.ptr[i].port_index, 14'h0000, s_d.ptr[i].queue_ptr};
              end
              OFF_POLICE_CTRL: begin
                s_d.rdata = {20'h00000, s_d.pol[i]};
              end
              // Count chosen by the selector for the pointed port and queue.
              OFF_POLICE_COUNT: begin
                s_d.rdata = policing_packet_counter_count_i[i];
              end
              // The index appears in the top lane for an access to lane 3, else in bits 1:0.
              OFF_TXQ_INDEX: begin
                if (haddr_i[1:0] == QIDX_BYTE_LANE) begin
                  s_d.rdata = {6'h00, s_d.qidx[i], 24'h000000};
                end else begin
                  s_d.rdata = {30'h00000000, s_d.qidx[i]};
                end
              end
              OFF_VID_REPLACE: begin
                s_d.rdata = {31'h00000000, s_d.vid[i]};
              end
              // Indexed scheduler byte.
              OFF_TXQ_SCHED: begin
                s_d.rdata = {24'h000000, s_d.sched[i][s_d.qidx[i]], 4'h0};
              end
              default: begin
              end
            endcase
          end
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign hrdata_o = s_q.rdata;
  assign hreadyout_o = s_q.ready;
  assign hresp_o = s_q.resp;
  assign police_cfg_o = s_q.pol;
  assign police_eff_o = s_q.eff;
  assign pointer_o = s_q.ptr;
  assign tx_queue_index_o = s_q.qidx;
  assign vid_replace_o = s_q.vid;
  assign vid_replace_outer_o = s_q.vid_outer;
  assign tx_sched_o = s_q.sched;

  // Checks on port 1, the first window.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  logic rd_take; // A read address phase is accepted.
  logic wr_pol0; // Word write to port 1 policing control in its data phase.
  logic wr_qb0; // Byte write to port 1 queue index top byte in its data phase.
  assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  assign wr_pol0 = s_q.wr_pend && s_q.wr_addr == {4'h1, OFF_POLICE_CTRL}
    && s_q.wr_size == HSIZE_WORD;
  assign wr_qb0 = s_q.wr_pend && s_q.wr_addr == {4'h1, OFF_TXQ_INDEX[11:2], QIDX_BYTE_LANE}
    && s_q.wr_size == HSIZE_BYTE;

  logic wr_qw0; // Word write to port 1 queue index in its data phase.
  logic wr_ptr0; // Word write to port 1 pointer in its data phase.
  logic wr_sch0; // Write to port 1 scheduler byte in its data phase.
  assign wr_qw0 = s_q.wr_pend && s_q.wr_addr == {4'h1, OFF_TXQ_INDEX}
    && s_q.wr_size == HSIZE_WORD;
  assign wr_ptr0 = s_q.wr_pend && s_q.wr_addr == {4'h1, OFF_PORT_POINTER}
    && s_q.wr_size == HSIZE_WORD;
  assign wr_sch0 = s_q.wr_pend && s_q.wr_addr == {4'h1, OFF_TXQ_SCHED};

  property p_enable_gates;
    wr_pol0 |=> police_eff_o[0].policing_on == $past(hwdata_i[0])
      && police_eff_o[0].wred_on == $past(hwdata_i[0]);
  endproperty
  a_enable_gates: assert property (p_enable_gates) else $error("enable not applied");

  property p_blind;
    police_eff_o[0].color_blind |-> police_cfg_o[0].enable && police_cfg_o[0].color_blind;
  endproperty
  a_blind: assert property (p_blind) else $error("color-blind without cause");

  property p_srp;
    police_eff_o[0].srp_drop_allowed |-> police_cfg_o[0].srp_drop && police_cfg_o[0].enable;
  endproperty
  a_srp: assert property (p_srp) else $error("stream drop without permission");

  property p_remap;
    police_eff_o[0].remap_on == (police_cfg_o[0].enable && !police_cfg_o[0].color_blind
      && police_cfg_o[0].remap);
  endproperty
  a_remap: assert property (p_remap) else $error("remap state wrong");

  property p_nonip;
    wr_pol0 |=> police_cfg_o[0].non_ip_frame_color == $past(hwdata_i[6:5]);
  endproperty
  a_nonip: assert property (p_nonip) else $error("non-IP color not stored");

  property p_qidx_byte;
    wr_qb0 |=> tx_queue_index_o[0] == $past(hwdata_i[25:24]);
  endproperty
  a_qidx_byte: assert property (p_qidx_byte) else $error("byte index write lost");

  property p_outer;
    vid_replace_outer_o[0] |-> vid_replace_o[0];
  endproperty
  a_outer: assert property (p_outer) else $error("outer replace without replace");

  property p_sched_legal;
    !tx_sched_o[0][0].mode[0] && !tx_sched_o[0][0].shaper[1];
  endproperty
  a_sched_legal: assert property (p_sched_legal) else $error("reserved mode held");

  property p_count_read;
    rd_take && haddr_i == {4'h1, OFF_POLICE_COUNT} |=> hrdata_o == $past(policing_packet_counter_count_i[0]);
  endproperty
  a_count_read: assert property (p_count_read) else $error("counter read wrong");

  property p_reserved_zero;
    rd_take && haddr_i == {4'h1, OFF_POLICE_CTRL} |=> hrdata_o[31:12] == 20'h00000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  // Color marking follows its bit only while policing is on.
  property p_mark;
    police_eff_o[0].mark_on == (police_cfg_o[0].enable && police_cfg_o[0].mark);
  endproperty
  a_mark: assert property (p_mark) else $error("mark state wrong");

  // Rates come from the pointed port only with per-port policing.
  property p_rate_sel;
    police_eff_o[0].rate_port_sel ==
      (police_cfg_o[0].port_based ? pointer_o[0].port_index : 3'h0);
  endproperty
  a_rate_sel: assert property (p_rate_sel) else $error("rate port wrong");

  // Drop-all needs both its bit and the enable.
  property p_drop_all;
    police_eff_o[0].drop_all |-> police_cfg_o[0].drop_all && police_cfg_o[0].enable;
  endproperty
  a_drop_all: assert property (p_drop_all) else $error("drop-all without cause");

  // The dropped-color choice passes straight to the counters.
  property p_drop_color;
    police_eff_o[0].drop_color_only == police_cfg_o[0].drop_color_only;
  endproperty
  a_drop_color: assert property (p_drop_color) else $error("color count mode wrong");

  // A word write to the queue index lands one cycle later.
  property p_qidx_word;
    wr_qw0 |=> tx_queue_index_o[0] == $past(hwdata_i[1:0]);
  endproperty
  a_qidx_word: assert property (p_qidx_word) else $error("word index write lost");

  // A word write to the pointer stores both of its fields.
  property p_ptr_write;
    wr_ptr0 |=> pointer_o[0].port_index == $past(hwdata_i[18:16])
      && pointer_o[0].queue_ptr == $past(hwdata_i[1:0]);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");

  // A legal mode written while the index names queue 0 lands in queue 0.
  property p_sched_mode;
    wr_sch0 && tx_queue_index_o[0] == 2'h0 && !hwdata_i[6]
      |=> tx_sched_o[0][0].mode == $past(hwdata_i[7:6]);
  endproperty
  a_sched_mode: assert property (p_sched_mode) else $error("scheduler mode lost");

  // A legal shaper written while the index names queue 0 lands in queue 0.
  property p_shaper;
    wr_sch0 && tx_queue_index_o[0] == 2'h0 && !hwdata_i[5]
      |=> tx_sched_o[0][0].shaper == $past(hwdata_i[5:4]);
  endproperty
  a_shaper: assert property (p_shaper) else $error("shaper mode lost");

  // Policing control changes only through a word write to it.
  property p_pol_hold;
    !wr_pol0 |=> $stable(police_cfg_o[0]);
  endproperty
  a_pol_hold: assert property (p_pol_hold) else $error("policing control changed");

  property p_bus_okay;
    hreadyout_o && !hresp_o;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("slave stalled or erred");

  c_pol_write: cover property (wr_pol0 ##1 police_eff_o[0].policing_on);
  c_qidx_byte: cover property (wr_qb0);
  c_sched_write: cover property (wr_sch0 && tx_queue_index_o[0] == 2'h0);
  c_count_read: cover property (rd_take && haddr_i == {4'h1, OFF_POLICE_COUNT});
  c_wrr_to_strict: cover property (tx_sched_o[0][0].mode == SCHED_STRICT);

endmodule

// ---- tb/tb.sv ----
// Self-checking testbench for the port policing and egress queue register bank.
`timescale 1ns/1ps
module tb
  import port_police_egress_pkg::*;
;
  logic clk_sys_i = 1'b0; // System clock, 100 MHz.
  logic rst_n_i = 1'b0; // Active-low reset, asserted at time zero.
  logic hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [2:0][31:0] policing_packet_counter = '0; // Counts offered by the counter datapath.
  logic [2:0] dtag = 3'h0; // Double tagging enables.
  police_ctrl_t [2:0] cfg;
  police_eff_t [2:0] effo;
  port_ptr_t [2:0] ptr;
  logic [2:0][1:0] qidx;
  logic [2:0] vid, vido;
  tx_sched_t [2:0][3:0] sch;
  int err_count = 0, checks = 0, seed = 32'hA4630888;
  // Reference copy of every port's registers, indexed by port number.
  logic [11:0] m_pc [1:3];
  logic [2:0] m_pi [1:3];
  logic [1:0] m_pq [1:3], m_idx [1:3];
  logic m_vid [1:3];
  logic [3:0] m_sch [1:3][0:3];
  localparam logic [11:0] OFFS [6] = '{OFF_PORT_POINTER, OFF_POLICE_CTRL, OFF_POLICE_COUNT,
    OFF_TXQ_INDEX, OFF_VID_REPLACE, OFF_TXQ_SCHED};
  localparam logic [11:0] WOFF [6] = '{OFF_PORT_POINTER, OFF_POLICE_CTRL, OFF_TXQ_INDEX,
    OFF_VID_REPLACE, OFF_TXQ_SCHED, 12'h903};

  port_police_egress_queue_ctrl #(.NUM_PORTS(3), .NUM_QUEUES(4)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .policing_packet_counter_count_i(policing_packet_counter), .double_tag_en_i(dtag), .police_cfg_o(cfg), .police_eff_o(effo),
    .pointer_o(ptr), .tx_queue_index_o(qidx), .vid_replace_o(vid),
    .vid_replace_outer_o(vido), .tx_sched_o(sch));

  // The clock toggles every half period.
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Waits for hready high at a rising edge, bounded so a stuck slave is caught.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      err_count++;
      $display("BAD %0t bus hang", $time);
    end
  endtask

  // One single AHB-Lite transfer: address phase, then data phase.
  task automatic xfer(input logic [15:0] a, input logic w, input logic [2:0] s,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= s;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk(32'(hresp), 32'h0, "response");
  endtask

  // Writes a register and updates the reference copy by the same rules.
  task automatic wr(input int p, input logic [11:0] off, input logic [2:0] sz,
                    input logic [31:0] d);
    logic [31:0] r;
    xfer({4'(p), off}, 1'b1, sz, d, r);
    if (p < 1 || p > 3) begin
      return;
    end
    if (off == OFF_TXQ_SCHED) begin
      if (!d[6]) m_sch[p][m_idx[p]][3:2] = d[7:6];
      if (!d[5]) m_sch[p][m_idx[p]][1:0] = d[5:4];
    end else if (off == OFF_TXQ_INDEX && sz == HSIZE_WORD) begin
      m_idx[p] = d[1:0];
    end else if (off == 12'h903 && sz == HSIZE_BYTE) begin
      m_idx[p] = d[25:24];
    end else if (sz == HSIZE_WORD) begin
      if (off == OFF_PORT_POINTER) {m_pi[p], m_pq[p]} = {d[18:16], d[1:0]};
      if (off == OFF_POLICE_CTRL) m_pc[p] = d[11:0];
      if (off == OFF_VID_REPLACE) m_vid[p] = d[0];
    end
  endtask

  // Expected read value of a register of one port.
  function automatic logic [31:0] rd_exp(int p, logic [11:0] off);
    case (off)
      OFF_PORT_POINTER: return {13'h0, m_pi[p], 14'h0, m_pq[p]};
      OFF_POLICE_CTRL: return {20'h0, m_pc[p]};
      OFF_POLICE_COUNT: return policing_packet_counter[p-1];
      OFF_TXQ_INDEX: return {30'h0, m_idx[p]};
      OFF_VID_REPLACE: return {31'h0, m_vid[p]};
      OFF_TXQ_SCHED: return {24'h0, m_sch[p][m_idx[p]], 4'h0};
      default: return 32'h0;
    endcase
  endfunction

  // Settings the policing datapath should apply, gated by the enable bit except the dropped-color choice and the rate port.
  function automatic logic [11:0] eff(int p);
    logic [11:0] c;
    logic en;
    c = m_pc[p];
    en = c[0];
    return {en, en, en & c[1], en & ~c[1], en & ~c[1] & c[3], en & c[4], en & c[2],
            en & c[10], c[11], c[7] ? m_pi[p] : 3'h0};
  endfunction

  // Reads back every register of a port, including the byte view of the index.
  task automatic check_regs(input int p);
    logic [31:0] r;
    for (int i = 0; i < 6; i++) begin
      xfer({4'(p), OFFS[i]}, 1'b0, HSIZE_WORD, 32'h0, r);
      chk(r, rd_exp(p, OFFS[i]), "readback");
    end
    xfer({4'(p), 12'h903}, 1'b0, HSIZE_BYTE, 32'h0, r);
    chk(r, {6'h0, m_idx[p], 24'h0}, "index byte");
  endtask

  // Compares every configuration output with the reference copy.
  task automatic check_outs();
    for (int p = 1; p <= 3; p++) begin
      chk(32'(cfg[p-1]), 32'(m_pc[p]), "cfg");
      chk(32'(effo[p-1]), 32'(eff(p)), "eff");
      chk(32'(ptr[p-1]), {27'h0, m_pi[p], m_pq[p]}, "pointer");
      chk(32'(qidx[p-1]), 32'(m_idx[p]), "index");
      chk(32'({vid[p-1], vido[p-1]}), 32'({m_vid[p], m_vid[p] & dtag[p-1]}), "vid");
      for (int q = 0; q < 4; q++) begin
        chk(32'(sch[p-1][q]), 32'(m_sch[p][q]), "sched");
      end
    end
  endtask

  // Main sequence: reset values, every scheduler code, random traffic, ignored accesses.
  initial begin
    int p;
    int op;
    logic [31:0] d;
    logic [31:0] r;
    for (int i = 1; i <= 3; i++) begin
      {m_pc[i], m_pi[i], m_pq[i], m_idx[i], m_vid[i]} = {12'h020, 8'h00};
      for (int q = 0; q < 4; q++) m_sch[i][q] = 4'h8;
    end
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int i = 1; i <= 3; i++) check_regs(i);
    check_outs();
    // Every scheduler byte code on every queue, index set by word and by byte.
    for (int q = 0; q < 4; q++) begin
      if (q[0]) wr(2, 12'h903, HSIZE_BYTE, 32'(q) << 24);
      else wr(2, OFF_TXQ_INDEX, HSIZE_WORD, 32'(q));
      for (int c = 0; c < 16; c++) begin
        wr(2, OFF_TXQ_SCHED, HSIZE_BYTE, 32'(c) << 4);
        xfer(16'h2914, 1'b0, HSIZE_WORD, 32'h0, r);
        chk(r, rd_exp(2, OFF_TXQ_SCHED), "sched read");
      end
      check_outs();
    end
    // Random writes with full readback and output comparison.
    for (int n = 0; n < 80; n++) begin
      p = 1 + $unsigned($random(seed)) % 3;
      op = $unsigned($random(seed)) % 6;
      d = $random(seed);
      policing_packet_counter <= {$random(seed), $random(seed), $random(seed)};
      dtag <= 3'($random(seed));
      wr(p, WOFF[op], op == 5 ? HSIZE_BYTE : HSIZE_WORD, d);
      check_regs(p);
      check_outs();
    end
    // Accesses that must leave every register untouched.
    wr(1, OFF_POLICE_CTRL, HSIZE_BYTE, 32'hFFFFFFFF);
    wr(1, 12'hA00, HSIZE_WORD, 32'hFFFFFFFF);
    wr(0, OFF_POLICE_CTRL, HSIZE_WORD, 32'hFFFFFFFF);
    xfer(16'h1A00, 1'b0, HSIZE_WORD, 32'h0, r);
    chk(r, 32'h0, "unmapped");
    xfer(16'h080C, 1'b0, HSIZE_WORD, 32'h0, r);
    chk(r, 32'h0, "no port");
    check_regs(1);
    check_outs();
    summarize();
  end

  // Watchdog: the run needs about 1600 cycles; give up after 20000.
  initial begin
    #200000;
    err_count++;
    $display("BAD %0t timeout", $time);
    summarize();
  end
endmodule
